/* File: src/amsr_pkg.sv */
// Purpose: constants for the amplifier status register bank
// Assumes: classic wishbone, 32-bit data, byte addressing
// Notes: status fields sit in the low 16 bits of one word
package amsr_pkg;
   localparam logic [7:0] ADDR_MISC_STATUS = 8'h54;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h58;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h5c;
   localparam logic [7:0] IDX_MISC_STATUS = 8'h15;
   localparam int BIT_SWITCHING = 14;
   localparam int BIT_REG_GOOD = 13;
   localparam int BIT_MODE_LO = 9;
   localparam int BIT_RATIO_IN2 = 8;
   localparam int BIT_HIGH_IN2 = 7;
   localparam int BIT_LOW_IN2 = 6;
   localparam int BIT_RATIO_IN1 = 5;
   localparam int BIT_HIGH_IN1 = 4;
   localparam int BIT_LOW_IN1 = 3;
   localparam int BIT_OC_CLEAR_A = 2;
   localparam int BIT_OC_CLEAR_B = 1;
   localparam int BIT_OT_CLEAR = 0;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] RESERVED_MASK = 16'h9800;
   localparam int NUM_COND = 13;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ON = 2'h3;
endpackage : amsr_pkg

/* File: src/amsr_sync.sv */
// Purpose: three-stage synchroniser for external condition levels
// Assumes: inputs are asynchronous levels
// Notes: output changes only when stages two and three agree
`timescale 1ns/1ps
module amsr_sync #(
   parameter int W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } amsr_sync_st_t;
   amsr_sync_st_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.out[i] = st_q.s3[i];
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign sync_o = st_q.out;
endmodule : amsr_sync

/* File: src/amsr_irq.sv */
// Purpose: sticky event bits with mask and one level interrupt
// Assumes: events are one-cycle pulses
// Notes: set wins over a write-one clear in the same cycle
`timescale 1ns/1ps
module amsr_irq #(
   parameter int W = 12
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] event_i,
   input wire logic [W-1:0] clear_i,
   input wire logic mask_we_i,
   input wire logic [W-1:0] mask_i,
   output logic [W-1:0] status_o,
   output logic [W-1:0] mask_o,
   output logic irq_o
);
   typedef struct packed {
      logic [W-1:0] sticky;
      logic [W-1:0] mask;
      logic irq;
   } amsr_irq_st_t;
   amsr_irq_st_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.sticky = (st_q.sticky & ~clear_i) | event_i;
      if (mask_we_i) begin
         st_d.mask = mask_i;
      end
      st_d.irq = |(st_d.sticky & st_d.mask);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign status_o = st_q.sticky;
   assign mask_o = st_q.mask;
   assign irq_o = st_q.irq;
   a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (event_i != '0) |=> ((status_o & $past(event_i)) == $past(event_i)))
      else $error("event lost against clear");
endmodule : amsr_irq

/* File: src/amsr_top.sv */
// Purpose: read-only amplifier miscellaneous status register on wishbone
// Assumes: condition levels come from detectors outside this clock domain
// Notes: live flags plus sticky change events with mask and interrupt
// Behaviour
// - bit 14 one while power stage switches
// - bit 13 one when analog regulator good
// - bits 10:9 report amplifier mode code
// - bits 8/5 flag invalid bit-clock ratio
// - bits 7/4 flag frame clock too fast
// - bits 6/3 flag frame clock too slow
// - bit 2 low while output A overcurrent
// - bit 1 low while output B overcurrent
// - bit 0 low while overtemperature engaged
// - status register ignores software writes
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module amsr_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic output_switching_i,
   input wire logic regulator_good_i,
   input wire logic [1:0] amp_mode_i,
   input wire logic bitclk_ratio_fault_in2_i,
   input wire logic frame_rate_high_in2_i,
   input wire logic frame_rate_low_in2_i,
   input wire logic bitclk_ratio_fault_in1_i,
   input wire logic frame_rate_high_in1_i,
   input wire logic frame_rate_low_in1_i,
   input wire logic overcurrent_active_a_i,
   input wire logic overcurrent_active_b_i,
   input wire logic overtemp_active_i
);
   localparam int NC = amsr_pkg::NUM_COND;
   typedef struct packed {
      logic [NC-1:0] prev;
      logic primed;
      logic ack;
      logic [31:0] dat;
   } amsr_st_t;
   amsr_st_t st_q, st_d;
   logic [NC-1:0] raw;
   logic [NC-1:0] cond;
   logic [15:0] status;
   logic [NC-1:0] evt;
   logic [NC-1:0] clr;
   logic mask_we;
   logic [NC-1:0] irq_status;
   logic [NC-1:0] irq_mask;
   logic irq_lvl;
   logic req;
   logic hit_status;
   logic hit_evt;
   logic hit_mask;
   logic hit_none;
   logic rd_status;

   // pack conditions in status order except regulator above switching, bit 0 = overtemp clear
   assign raw = {regulator_good_i, output_switching_i, amp_mode_i,
      bitclk_ratio_fault_in2_i, frame_rate_high_in2_i, frame_rate_low_in2_i,
      bitclk_ratio_fault_in1_i, frame_rate_high_in1_i, frame_rate_low_in1_i,
      ~overcurrent_active_a_i, ~overcurrent_active_b_i, ~overtemp_active_i};

   amsr_sync #(.W(NC)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(raw),
      .sync_o(cond)
   );

   always_comb begin
      status = amsr_pkg::STATUS_RESET;
      status[amsr_pkg::BIT_SWITCHING] = cond[11];
      status[amsr_pkg::BIT_REG_GOOD] = cond[12];
      status[amsr_pkg::BIT_MODE_LO +: 2] = cond[10:9];
      status[amsr_pkg::BIT_RATIO_IN2] = cond[8];
      status[amsr_pkg::BIT_HIGH_IN2] = cond[7];
      status[amsr_pkg::BIT_LOW_IN2] = cond[6];
      status[amsr_pkg::BIT_RATIO_IN1] = cond[5];
      status[amsr_pkg::BIT_HIGH_IN1] = cond[4];
      status[amsr_pkg::BIT_LOW_IN1] = cond[3];
      status[amsr_pkg::BIT_OC_CLEAR_A] = cond[2];
      status[amsr_pkg::BIT_OC_CLEAR_B] = cond[1];
      status[amsr_pkg::BIT_OT_CLEAR] = cond[0];
   end

   // a change of any condition in either direction is an event
   assign evt = st_q.primed ? (cond ^ st_q.prev) : '0;
   assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
   assign mask_we = req & wb_we_i & (wb_adr_i == amsr_pkg::ADDR_IRQ_MASK) & wb_sel_i[0];
   assign clr = (req & wb_we_i & (wb_adr_i == amsr_pkg::ADDR_IRQ_STATUS) & wb_sel_i[0])
      ? wb_dat_i[NC-1:0] : '0;
   assign hit_status = (wb_adr_i == amsr_pkg::ADDR_MISC_STATUS);
   assign hit_evt = (wb_adr_i == amsr_pkg::ADDR_IRQ_STATUS);
   assign hit_mask = (wb_adr_i == amsr_pkg::ADDR_IRQ_MASK);
   assign hit_none = ~(hit_status | hit_evt | hit_mask);
   assign rd_status = req & ~wb_we_i & hit_status;

   amsr_irq #(.W(NC)) u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .event_i(evt),
      .clear_i(clr),
      .mask_we_i(mask_we),
      .mask_i(wb_dat_i[NC-1:0]),
      .status_o(irq_status),
      .mask_o(irq_mask),
      .irq_o(irq_lvl)
   );

   always_comb begin
      st_d = st_q;
      st_d.prev = cond;
      st_d.primed = 1'b1;
      st_d.ack = req;
      st_d.dat = 32'h0000_0000;
      if (req && !wb_we_i) begin
         // reads only sample; no flag is touched
         if (wb_adr_i == amsr_pkg::ADDR_MISC_STATUS) begin
            st_d.dat = {16'h0000, status};
         end else if (wb_adr_i == amsr_pkg::ADDR_IRQ_STATUS) begin
            st_d.dat = {{(32-NC){1'b0}}, irq_status};
         end else if (wb_adr_i == amsr_pkg::ADDR_IRQ_MASK) begin
            st_d.dat = {{(32-NC){1'b0}}, irq_mask};
         end
      end
      // writes to the status word are acked and dropped
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.dat;
   assign irq_o = irq_lvl;

   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> ((wb_dat_o & {16'hffff, amsr_pkg::RESERVED_MASK}) == 32'h0))
      else $error("reserved bits not zero");
   a_read_live: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && wb_adr_i == amsr_pkg::ADDR_MISC_STATUS)
      |=> (wb_dat_o[15:0] == $past(status)))
      else $error("status read not live");
   a_switch_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      status[14] == cond[11])
      else $error("switching bit wrong");
   a_reg_good: assert property (@(posedge clk_i) disable iff (rst_i)
      status[13] == cond[12])
      else $error("regulator bit wrong");
   a_mode_field: assert property (@(posedge clk_i) disable iff (rst_i)
      status[10:9] == cond[10:9])
      else $error("mode field wrong");
   a_in2_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      status[8:6] == cond[8:6])
      else $error("input 2 flags wrong");
   a_in1_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      status[5:3] == cond[5:3])
      else $error("input 1 flags wrong");
   a_oc_low: assert property (@(posedge clk_i) disable iff (rst_i)
      status[2] == cond[2])
      else $error("overcurrent a polarity");
   a_ot_low: assert property (@(posedge clk_i) disable iff (rst_i)
      status[0] == cond[0])
      else $error("overtemp bit wrong");
   a_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i) |=> (wb_ack_o && wb_dat_o == 32'h0))
      else $error("write altered read data");
   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_oc_b_low: assert property (@(posedge clk_i) disable iff (rst_i)
      status[1] == cond[1])
      else $error("overcurrent b bit wrong");

   // a status read returns each field as it stood at the request edge
   a_rd_switch: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> (wb_dat_o[amsr_pkg::BIT_SWITCHING] == $past(cond[11])))
      else $error("read switching bit wrong");
   a_rd_reg_good: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> (wb_dat_o[amsr_pkg::BIT_REG_GOOD] == $past(cond[12])))
      else $error("read regulator bit wrong");
   a_rd_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> (wb_dat_o[10:9] == $past(cond[10:9])))
      else $error("read mode field wrong");
   a_rd_ratio: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> ({wb_dat_o[8], wb_dat_o[5]} == $past({cond[8], cond[5]})))
      else $error("read ratio flags wrong");
   a_rd_high: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> ({wb_dat_o[7], wb_dat_o[4]} == $past({cond[7], cond[4]})))
      else $error("read fast flags wrong");
   a_rd_low: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> ({wb_dat_o[6], wb_dat_o[3]} == $past({cond[6], cond[3]})))
      else $error("read slow flags wrong");
   a_rd_oc_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> (wb_dat_o[2] == $past(cond[2])))
      else $error("read overcurrent a wrong");
   a_rd_oc_b: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> (wb_dat_o[1] == $past(cond[1])))
      else $error("read overcurrent b wrong");
   a_rd_ot: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> (wb_dat_o[0] == $past(cond[0])))
      else $error("read overtemp bit wrong");
   a_rd_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      rd_status
      |=> ({wb_dat_o[31:15], wb_dat_o[12:11]} == 19'h0))
      else $error("read reserved bits set");

   // bus side: one acknowledge per request, data only beside it
   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      req
      |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
      !req
      |=> !wb_ack_o)
      else $error("acknowledge without request");
   a_dat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o
      |-> (wb_dat_o == 32'h0))
      else $error("read data outside acknowledge");
   a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && hit_none)
      |=> (wb_dat_o == 32'h0))
      else $error("unmapped read not zero");
   a_write_no_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i && hit_status && evt == '0)
      |=> ($stable(irq_status) && $stable(irq_mask)))
      else $error("status write touched event state");
   a_read_no_side: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && evt == '0)
      |=> $stable(irq_status))
      else $error("read changed event state");
   a_status_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      (status & amsr_pkg::RESERVED_MASK) == 16'h0)
      else $error("reserved status bits set");

   // event and mask state
   a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
      mask_we
      |=> (irq_mask == $past(wb_dat_i[NC-1:0])))
      else $error("mask write lost");
   a_mask_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !mask_we
      |=> $stable(irq_mask))
      else $error("mask changed without write");
   a_mask_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && hit_mask)
      |=> (wb_dat_o == {{(32-NC){1'b0}}, $past(irq_mask)}))
      else $error("mask read wrong");
   a_evt_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i && hit_evt)
      |=> (wb_dat_o == {{(32-NC){1'b0}}, $past(irq_status)}))
      else $error("event read wrong");
   a_clear_works: assert property (@(posedge clk_i) disable iff (rst_i)
      (clr != '0)
      |=> ((irq_status & $past(clr & ~evt)) == '0))
      else $error("event clear lost");
   a_sticky_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      ((irq_status & ~clr) != '0)
      |=> ((irq_status & $past(irq_status & ~clr)) == $past(irq_status & ~clr)))
      else $error("event bit dropped without clear");
   a_evt_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      (evt == '0 && clr == '0)
      |=> $stable(irq_status))
      else $error("event bit set without change");
   a_primed_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      !st_q.primed
      |-> (evt == '0))
      else $error("event before first sample");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_o == |(irq_status & irq_mask))
      else $error("interrupt level wrong");

   // every synchronised change lands in its sticky bit one cycle later
   for (genvar i = 0; i < NC; i++) begin : g_evt_chk
      a_evt_lands: assert property (@(posedge clk_i) disable iff (rst_i)
         (st_q.primed && cond[i] != st_q.prev[i]) |=> irq_status[i])
         else $error("condition change not recorded");
   end
endmodule : amsr_top

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for the amplifier status register bank
// Assumes: wishbone answers within a few cycles, flags settle 4 cycles after a change
// Notes: random condition patterns with walking-one corner cases first
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic irq_o;
   // cond: 0 ot, 1 oc_b, 2 oc_a, 3-8 serial flags, 10:9 mode, 11 switching, 12 regulator
   logic [12:0] cond = 13'h0;
   logic [31:0] rd;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;

   always #50 clk_i = ~clk_i;

   amsr_top uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .output_switching_i(cond[11]),
      .regulator_good_i(cond[12]), .amp_mode_i(cond[10:9]),
      .bitclk_ratio_fault_in2_i(cond[8]), .frame_rate_high_in2_i(cond[7]),
      .frame_rate_low_in2_i(cond[6]), .bitclk_ratio_fault_in1_i(cond[5]),
      .frame_rate_high_in1_i(cond[4]), .frame_rate_low_in1_i(cond[3]),
      .overcurrent_active_a_i(cond[2]), .overcurrent_active_b_i(cond[1]),
      .overtemp_active_i(cond[0])
   );

   function automatic logic [31:0] exp_status(input logic [12:0] c);
      return {16'h0000, 1'b0, c[11], c[12], 2'b00, c[10:9], c[8:3], ~c[2], ~c[1], ~c[0]};
   endfunction : exp_status

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hf;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         $display("unexpected at %0t: no acknowledge", $time);
      end
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic set_cond(input logic [12:0] c);
      @(posedge clk_i);
      cond <= c;
      repeat (6) @(posedge clk_i);
   endtask : set_cond

   task automatic check_irq(input logic exp);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq_o}, {31'h0, exp});
   endtask : check_irq

   always @(posedge clk_i) begin
      cycles++;
      if (cycles >= 20000) begin
         error_cnt++;
         $display("unexpected at %0t: run too long", $time);
         results();
      end
   end

   initial begin
      void'($urandom(14));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, amsr_pkg::ADDR_IRQ_MASK, 32'h0);
      check(rd, 32'h0);
      wb(1'b1, 8'h60, 32'hffffffff);
      wb(1'b0, 8'h60, 32'h0);
      check(rd, 32'h0);
      $display("test map done");
      for (int i = 0; i < 29; i++) begin
         set_cond(i < 13 ? 13'h1 << i : 13'($urandom));
         wb(1'b0, amsr_pkg::ADDR_MISC_STATUS, 32'h0);
         check(rd, exp_status(cond));
         wb(1'b0, amsr_pkg::ADDR_MISC_STATUS, 32'h0);
         check(rd, exp_status(cond));
         wb(1'b1, amsr_pkg::ADDR_MISC_STATUS, ~exp_status(cond));
         wb(1'b0, amsr_pkg::ADDR_MISC_STATUS, 32'h0);
         check(rd, exp_status(cond));
      end
      $display("test status done");
      wb(1'b1, amsr_pkg::ADDR_IRQ_STATUS, 32'h1fff);
      wb(1'b0, amsr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check(rd, 32'h0);
      check_irq(1'b0);
      wb(1'b1, amsr_pkg::ADDR_IRQ_MASK, 32'h1);
      set_cond(cond ^ 13'h1);
      wb(1'b0, amsr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check(rd, 32'h1);
      check_irq(1'b1);
      wb(1'b1, amsr_pkg::ADDR_IRQ_MASK, 32'h0);
      check_irq(1'b0);
      wb(1'b1, amsr_pkg::ADDR_IRQ_MASK, 32'h1);
      check_irq(1'b1);
      wb(1'b1, amsr_pkg::ADDR_IRQ_STATUS, 32'h1);
      check_irq(1'b0);
      wb(1'b0, amsr_pkg::ADDR_IRQ_STATUS, 32'h0);
      check(rd, 32'h0);
      $display("test interrupt done");
      results();
   end
endmodule : tb_top
